// ==== design/dacm_top.sv ====
// control and mute logic of a stereo dac: ratio check, control modes,
// serial control port, automute and soft mute decay
// assumes samples arrive on the core clock; all pins are asynchronous
`timescale 1ns/10ps
module dacm_top (
  // clock and reset
  input  wire logic        i_core_clk,
  input  wire logic        i_rst,
  // audio clocks
  input  wire logic        i_frame_clock,
  input  wire logic        i_bit_clock,
  // control pins
  input  wire logic        i_mode_pin,
  input  wire logic        i_ctrl_clk,
  input  wire logic        i_serial_data_deemph_pin,
  input  wire logic        i_latch_format_pin,
  input  wire logic        i_select_wordlen_pin,
  // mute pin sense
  input  wire logic        i_mute_control_pin,
  input  wire logic        i_mute_undriven,
  // decoded samples
  input  wire logic        i_sample_valid,
  input  wire logic [23:0] i_sample_left,
  input  wire logic [23:0] i_sample_right,
  // mute pin and data pin drive
  output logic             o_mute_control_pin,
  output logic             o_mute_control_oe_n,
  output logic             o_sdi_out,
  output logic             o_sdi_oe_n,
  // status
  output logic             o_zero_n,
  output logic             o_dac_mute,
  output logic             o_dac_shutdown,
  output logic             o_sw_mode,
  output logic             o_three_wire,
  // format selection
  output logic             o_fmt_i2s,
  output logic [1:0]       o_word_len,
  output logic             o_deemph,
  // filtered samples
  output logic             o_out_valid,
  output logic [23:0]      o_out_left,
  output logic [23:0]      o_out_right
);

  dacm_pin_if pins ();

  assign pins.raw = {i_mute_undriven, i_mute_control_pin, i_select_wordlen_pin,
                     i_latch_format_pin, i_serial_data_deemph_pin, i_ctrl_clk,
                     i_bit_clock, i_frame_clock, i_mode_pin};

  dacm_sync u_sync (
    .i_clk (i_core_clk),
    .i_rst (i_rst),
    .pins  (pins)
  );

  logic mode_s, frame_s, bclk_s, sck_s, sdi_s, lat_s, selwl_s, mute_s, undriven_s;
  logic mode_q, frame_q, bclk_q, sck_q, sdi_q, lat_q;

  // synchronised pin levels
  assign mode_s     = pins.synced[dacm_pkg::SY_MODE];
  assign frame_s    = pins.synced[dacm_pkg::SY_FRAME];
  assign bclk_s     = pins.synced[dacm_pkg::SY_BCLK];
  assign sck_s      = pins.synced[dacm_pkg::SY_SCK];
  assign sdi_s      = pins.synced[dacm_pkg::SY_SDI];
  assign lat_s      = pins.synced[dacm_pkg::SY_LATCH];
  assign selwl_s    = pins.synced[dacm_pkg::SY_SELWL];
  assign mute_s     = pins.synced[dacm_pkg::SY_MUTE];
  assign undriven_s = pins.synced[dacm_pkg::SY_UNDRIVEN];

  // previous levels for edge detection
  always_ff @(posedge i_core_clk) begin
    if (i_rst) begin
      mode_q  <= 1'b0;
      frame_q <= 1'b0;
      bclk_q  <= 1'b0;
      sck_q   <= 1'b0;
      sdi_q   <= 1'b0;
      lat_q   <= 1'b0;
    end else begin
      mode_q  <= mode_s;
      frame_q <= frame_s;
      bclk_q  <= bclk_s;
      sck_q   <= sck_s;
      sdi_q   <= sdi_s;
      lat_q   <= lat_s;
    end
  end

  logic frame_rise, bclk_rise, sck_rise, sck_fall, lat_rise, lat_fall, mode_chg;
  assign frame_rise = frame_s & ~frame_q;
  assign bclk_rise  = bclk_s & ~bclk_q;
  assign sck_rise   = sck_s & ~sck_q;
  assign sck_fall   = ~sck_s & sck_q;
  assign lat_rise   = lat_s & ~lat_q;
  assign lat_fall   = ~lat_s & lat_q;
  assign mode_chg   = mode_s ^ mode_q;

  // true when a measured period sits within tolerance of a legal ratio
  function automatic logic ratio_ok(input logic [11:0] p);
    logic ok;
    ok = 1'b0;
    for (int k = 0; k < 6; k++) begin
      if (p >= dacm_pkg::MCLK_RATIOS[k] - dacm_pkg::MCLK_TOL &&
          p <= dacm_pkg::MCLK_RATIOS[k] + dacm_pkg::MCLK_TOL) begin
        ok = 1'b1;
      end
    end
    return ok;
  endfunction

  logic [11:0] period_q;
  logic        ratio_err_q;
  logic        period_ok;
  assign period_ok = ratio_ok(period_q);

  // period counter; starts in error so nothing plays before a good frame
  always_ff @(posedge i_core_clk) begin
    if (i_rst) begin
      period_q    <= 12'h000;
      ratio_err_q <= 1'b1;
    end else if (frame_rise) begin
      period_q    <= dacm_pkg::PERIOD_ONE;
      ratio_err_q <= ~period_ok;
    end else if (period_q == dacm_pkg::PERIOD_MAX) begin
      ratio_err_q <= 1'b1;           // stopped frame clock counts as a mismatch
    end else begin
      period_q <= period_q + dacm_pkg::PERIOD_ONE;
    end
  end

  logic [5:0] hi_q, lo_q;
  logic       auto16_q;

  // bit clocks per frame half; a lone 16/16 frame forces 16-bit data
  always_ff @(posedge i_core_clk) begin
    if (i_rst) begin
      hi_q     <= 6'h00;
      lo_q     <= 6'h00;
      auto16_q <= 1'b0;
    end else if (frame_rise) begin
      auto16_q <= (hi_q == dacm_pkg::BCLK_HALF) && (lo_q == dacm_pkg::BCLK_HALF);
      hi_q     <= 6'h00;
      lo_q     <= 6'h00;
    end else if (bclk_rise) begin
      if (frame_s && hi_q != dacm_pkg::BCLK_SAT) begin
        hi_q <= hi_q + 6'h01;
      end
      if (!frame_s && lo_q != dacm_pkg::BCLK_SAT) begin
        lo_q <= lo_q + 6'h01;
      end
    end
  end

  logic three_wire_q, lat_seen_q;

  // 2-wire by default; one latch pulse locks 3-wire until the mode pin moves
  always_ff @(posedge i_core_clk) begin
    if (i_rst || mode_chg) begin
      three_wire_q <= 1'b0;
      lat_seen_q   <= 1'b0;
    end else if (mode_s && !three_wire_q) begin
      if (lat_rise) begin
        lat_seen_q <= 1'b1;
      end
      if (lat_fall && lat_seen_q) begin
        three_wire_q <= 1'b1;
      end
    end
  end

  logic [15:0] sh3_q;
  logic        write3;

  // 3-wire shift register, msb first on control clock rise
  always_ff @(posedge i_core_clk) begin
    if (i_rst) begin
      sh3_q <= 16'h0000;
    end else if (mode_s && three_wire_q && sck_rise) begin
      sh3_q <= {sh3_q[14:0], sdi_s};
    end
  end

  // word applied on latch rise; chip select must be low
  assign write3 = mode_s & three_wire_q & lat_rise & ~selwl_s;

  dacm_pkg::dacm_tw_state_e tw_state_q;
  logic [3:0] tw_cnt_q;
  logic [7:0] tw_byte_q, tw_hi_q;
  logic       ack_q, tw_active, tw_start, tw_stop, tw_accept, write2;

  assign tw_active = mode_s & ~three_wire_q;
  assign tw_start  = sck_s & sck_q & sdi_q & ~sdi_s;
  assign tw_stop   = sck_s & sck_q & ~sdi_q & sdi_s;
  assign tw_accept = (tw_state_q != dacm_pkg::TW_ADDR) ||
                     (tw_byte_q == {dacm_pkg::TW_ADDR_HI, selwl_s, 1'b0});
  assign write2    = tw_active & ~tw_start & ~tw_stop & sck_rise & ack_q &
                     (tw_state_q == dacm_pkg::TW_LO) & (tw_cnt_q == dacm_pkg::BYTE_BITS);

  // 2-wire receiver: address byte, then two data bytes, each acknowledged
  always_ff @(posedge i_core_clk) begin
    if (i_rst || !tw_active) begin
      tw_state_q <= dacm_pkg::TW_IDLE;
      tw_cnt_q   <= 4'h0;
      tw_byte_q  <= 8'h00;
      tw_hi_q    <= 8'h00;
      ack_q      <= 1'b0;
    end else if (tw_start) begin
      tw_state_q <= dacm_pkg::TW_ADDR;
      tw_cnt_q   <= 4'h0;
      ack_q      <= 1'b0;
    end else if (tw_stop) begin
      tw_state_q <= dacm_pkg::TW_IDLE;
      ack_q      <= 1'b0;
    end else begin
      case (tw_state_q)
        dacm_pkg::TW_IDLE, dacm_pkg::TW_IGNORE: begin
          ack_q <= 1'b0;
        end
        dacm_pkg::TW_ADDR, dacm_pkg::TW_HI, dacm_pkg::TW_LO: begin
          if (sck_rise && tw_cnt_q != dacm_pkg::BYTE_BITS) begin
            tw_byte_q <= {tw_byte_q[6:0], sdi_s};
            tw_cnt_q  <= tw_cnt_q + 4'h1;
          end else if (sck_rise) begin
            tw_cnt_q <= 4'h0;
            if (!ack_q) begin
              tw_state_q <= dacm_pkg::TW_IGNORE;
            end else if (tw_state_q == dacm_pkg::TW_ADDR) begin
              tw_state_q <= dacm_pkg::TW_HI;
            end else if (tw_state_q == dacm_pkg::TW_HI) begin
              tw_state_q <= dacm_pkg::TW_LO;
              tw_hi_q    <= tw_byte_q;
            end else begin
              tw_state_q <= dacm_pkg::TW_IGNORE;  // bytes past the word are dropped
            end
          end
          if (sck_fall) begin
            ack_q <= (tw_cnt_q == dacm_pkg::BYTE_BITS) && tw_accept;
          end
        end
        default: begin
          tw_state_q <= dacm_pkg::TW_IDLE;
        end
      endcase
    end
  end

  logic        wr_en;
  logic [15:0] wr_word;
  logic [6:0]  wr_addr;
  logic [1:0]  wr_idx;
  logic [8:0]  wr_data;
  assign wr_en   = write3 | write2;
  assign wr_word = three_wire_q ? sh3_q : {tw_hi_q, tw_byte_q};
  assign wr_addr = wr_word[15:dacm_pkg::CW_ADDR_LSB];
  assign wr_idx  = wr_addr[1:0];
  assign wr_data = wr_word[dacm_pkg::CW_ADDR_LSB-1:0];

  logic [3:0][8:0] regs_q;

  // program registers; unknown addresses are ignored
  always_ff @(posedge i_core_clk) begin
    if (i_rst) begin
      regs_q[dacm_pkg::REG_ATT_L]   <= dacm_pkg::REG0_RST;
      regs_q[dacm_pkg::REG_ATT_R]   <= dacm_pkg::REG1_RST;
      regs_q[dacm_pkg::REG_DAC_CTL] <= dacm_pkg::REG2_RST;
      regs_q[dacm_pkg::REG_IF_CTL]  <= dacm_pkg::REG3_RST;
    end else if (wr_en && wr_addr < dacm_pkg::NUM_REGS) begin
      regs_q[wr_idx] <= wr_data;
    end
  end

  logic        izd_bit, zero_en, zlatch_q, both_zero;
  logic [10:0] run_q;
  assign izd_bit   = regs_q[dacm_pkg::REG_IF_CTL][dacm_pkg::R3_IZD];
  assign zero_en   = undriven_s | izd_bit;
  assign both_zero = (i_sample_left == 24'h000000) && (i_sample_right == 24'h000000);

  // zero run counter and automute latch
  always_ff @(posedge i_core_clk) begin
    if (i_rst || !zero_en) begin
      run_q    <= 11'h000;
      zlatch_q <= 1'b0;
    end else if (i_sample_valid && both_zero) begin
      if (run_q == dacm_pkg::ZERO_RUN - 11'h001) begin
        zlatch_q <= 1'b1;
      end else begin
        run_q <= run_q + 11'h001;
      end
    end else if (i_sample_valid) begin
      run_q    <= 11'h000;
      zlatch_q <= 1'b0;
    end
  end

  logic pin_low, shutdown_d, mute_d;
  // an undriven pin follows our own weak drive, so it reads the latch
  assign pin_low    = undriven_s ? zlatch_q : ~mute_s;
  assign shutdown_d = ratio_err_q | (mode_s & regs_q[dacm_pkg::REG_DAC_CTL][dacm_pkg::R2_PWDN]);
  assign mute_d     = pin_low | (izd_bit & zlatch_q) | shutdown_d |
                      (mode_s & regs_q[dacm_pkg::REG_DAC_CTL][dacm_pkg::R2_MUTE]);

  // status and pin drive outputs
  always_ff @(posedge i_core_clk) begin
    if (i_rst) begin
      o_mute_control_pin  <= 1'b1;
      o_mute_control_oe_n <= 1'b1;
      o_sdi_out           <= 1'b0;
      o_sdi_oe_n          <= 1'b1;
      o_zero_n            <= 1'b1;
      o_dac_mute          <= 1'b1;
      o_dac_shutdown      <= 1'b1;
      o_sw_mode           <= 1'b0;
      o_three_wire        <= 1'b0;
    end else begin
      o_mute_control_pin  <= ~zlatch_q;
      o_mute_control_oe_n <= ~undriven_s;
      o_sdi_out           <= 1'b0;
      o_sdi_oe_n          <= ~ack_q;
      o_zero_n            <= ~zlatch_q;
      o_dac_mute          <= mute_d;
      o_dac_shutdown      <= shutdown_d;
      o_sw_mode           <= mode_s;
      o_three_wire        <= three_wire_q;
    end
  end

  logic       i2s_d, deemph_d;
  logic [1:0] wl_d;

  // format source: pins in hardware mode, registers in software mode
  always_comb begin
    if (mode_s) begin
      i2s_d    = regs_q[dacm_pkg::REG_IF_CTL][dacm_pkg::R3_I2S];
      wl_d     = regs_q[dacm_pkg::REG_DAC_CTL][dacm_pkg::R2_IW_MSB:dacm_pkg::R2_IW_LSB];
      deemph_d = regs_q[dacm_pkg::REG_DAC_CTL][dacm_pkg::R2_DEEMPH];
    end else begin
      i2s_d    = lat_s;
      deemph_d = sdi_s;
      case ({lat_s, selwl_s})
        2'b00:   wl_d = dacm_pkg::WL24;
        2'b01:   wl_d = dacm_pkg::WL20;
        2'b10:   wl_d = dacm_pkg::WL16;
        default: wl_d = dacm_pkg::WL24;
      endcase
    end
    if (auto16_q) begin
      wl_d = dacm_pkg::WL16;
    end
  end

  // format outputs
  always_ff @(posedge i_core_clk) begin
    if (i_rst) begin
      o_fmt_i2s  <= 1'b0;
      o_word_len <= dacm_pkg::WL24;
      o_deemph   <= 1'b0;
    end else begin
      o_fmt_i2s  <= i2s_d;
      o_word_len <= wl_d;
      o_deemph   <= deemph_d;
    end
  end

  // one decay step toward zero; tiny values still step so mute settles
  function automatic logic [23:0] decay(input logic [23:0] y);
    logic [23:0] st;
    st = $signed(y) >>> dacm_pkg::DECAY_SHIFT;
    if (st == 24'h000000 && y != 24'h000000) begin
      st = y[23] ? 24'hffffff : 24'h000001;
    end
    return y - st;
  endfunction

  // soft mute: exponential decay from the held sample, instant release
  always_ff @(posedge i_core_clk) begin
    if (i_rst) begin
      o_out_valid <= 1'b0;
      o_out_left  <= 24'h000000;
      o_out_right <= 24'h000000;
    end else begin
      o_out_valid <= i_sample_valid;
      if (i_sample_valid) begin
        o_out_left  <= o_dac_mute ? decay(o_out_left) : i_sample_left;
        o_out_right <= o_dac_mute ? decay(o_out_right) : i_sample_right;
      end
    end
  end

  default clocking cb @(posedge i_core_clk); endclocking
  default disable iff (i_rst);

  chk_ratio_shut: assert property (frame_rise && !period_ok |-> ##2 o_dac_shutdown)
    else $error("ratio mismatch did not shut down");
  chk_pin_mute: assert property (!undriven_s && !mute_s |=> o_dac_mute)
    else $error("driven low mute pin did not mute");
  chk_auto_drive: assert property (undriven_s && zlatch_q |=> !o_mute_control_oe_n && !o_mute_control_pin)
    else $error("undriven mute pin not driven low on zero");
  chk_run_latch: assert property (zero_en && i_sample_valid && both_zero && run_q == 11'h3ff |=> zlatch_q ##1 !o_zero_n)
    else $error("zero run did not set latch");
  chk_zero_clear: assert property (zero_en && i_sample_valid && !both_zero |=> !zlatch_q ##1 o_zero_n)
    else $error("non-zero sample did not clear latch");
  chk_izd_gate: assert property (!undriven_s && mute_s && izd_bit && zlatch_q |=> o_dac_mute)
    else $error("zero-detect bit did not mute");
  chk_decay_step: assert property (i_sample_valid && o_dac_mute && !o_out_left[23] && o_out_left != 24'h000000 |=> o_out_left < $past(o_out_left) && !o_out_left[23])
    else $error("muted output did not decay");
  chk_release_pass: assert property (i_sample_valid && !o_dac_mute |=> o_out_left == $past(i_sample_left))
    else $error("unmuted output not passed through");
  chk_hw_format: assert property (!mode_s && !auto16_q && lat_s && !selwl_s |=> o_word_len == dacm_pkg::WL16 && o_fmt_i2s)
    else $error("hardware format decode wrong");
  chk_auto16: assert property (frame_rise && hi_q == 6'h10 && lo_q == 6'h10 |-> ##2 o_word_len == dacm_pkg::WL16)
    else $error("16/16 frame did not force 16-bit");
  chk_hw_deemph: assert property (!mode_s |=> o_deemph == $past(sdi_s))
    else $error("de-emphasis pin not followed");
  chk_sw_format: assert property (mode_s |=> o_fmt_i2s == $past(i2s_d) && o_fmt_i2s == $past(regs_q[3][0]))
    else $error("software format not from register");
  chk_reg_write: assert property (wr_en && wr_addr < 7'h04 |=> regs_q[$past(wr_idx)] == $past(wr_data))
    else $error("control word not stored");
  chk_three_sticky: assert property (three_wire_q && !mode_chg |=> three_wire_q)
    else $error("3-wire mode left without mode change");
  chk_addr_nack: assert property (tw_active && !tw_start && !tw_stop && tw_state_q == dacm_pkg::TW_ADDR && tw_cnt_q == 4'h8 && sck_fall && !tw_accept |=> ##1 o_sdi_oe_n)
    else $error("wrong address acknowledged");

endmodule

// ==== include/dacm_pkg.sv ====
// constants, state codes and field layout for the dac control and mute logic
// assumes a single core clock that also serves as the master clock
// Contract
// - frame period off by over 32 clocks shuts down
// - mode pin low hardware, high software control
// - mute pin low mutes, high runs normally
// - undriven mute pin shows automute, low when zero
// - zero output low while infinite zero detected
// - mute decays toward mid rail, tau 64 samples
// - 1024 zero samples both channels set automute latch
// - any non-zero sample clears the automute latch
// - mute pin high blocks automute unless zero-detect bit
// - hardware pins select one of four input formats
// - 16 high 16 low bit clocks forces 16-bit
// - hardware mode data pin enables de-emphasis
// - 3-wire word shifted in, captured on latch pulse
// - word bits 15-9 address, 8-0 data
// - software mode starts in 2-wire control
// - 2-wire address 001101 plus select pin bit
// - latch pulse in 2-wire mode locks 3-wire mode
// - register 3 bit 8 enables zero detect, reset off
// - four 9-bit program registers loaded serially
// - control pins resynchronised into the core clock
package dacm_pkg;

  // positions of the pin levels inside the synchroniser bank
  localparam int SYNC_W      = 9;
  localparam int SY_MODE     = 0;
  localparam int SY_FRAME    = 1;
  localparam int SY_BCLK     = 2;
  localparam int SY_SCK      = 3;
  localparam int SY_SDI      = 4;
  localparam int SY_LATCH    = 5;
  localparam int SY_SELWL    = 6;
  localparam int SY_MUTE     = 7;
  localparam int SY_UNDRIVEN = 8;

  // master clock to frame ratio check
  localparam logic [11:0]      MCLK_TOL    = 12'h020;
  localparam logic [5:0][11:0] MCLK_RATIOS = {12'h300, 12'h200, 12'h180,
                                              12'h100, 12'h0c0, 12'h080};
  localparam logic [11:0]      PERIOD_MAX  = 12'hfff;
  localparam logic [11:0]      PERIOD_ONE  = 12'h001;

  // bit clocks per frame half that force 16-bit data
  localparam logic [5:0] BCLK_HALF = 6'h10;
  localparam logic [5:0] BCLK_SAT  = 6'h3f;

  // zero run and soft mute decay
  localparam logic [10:0] ZERO_RUN    = 11'h400;
  localparam int          DECAY_SHIFT = 6;

  // serial control words
  localparam logic [5:0] TW_ADDR_HI  = 6'h0d;
  localparam logic [3:0] BYTE_BITS   = 4'h8;
  localparam int         CW_ADDR_LSB = 9;
  localparam logic [6:0] NUM_REGS    = 7'h04;

  // program register indexes and reset values
  localparam int         REG_ATT_L   = 0;
  localparam int         REG_ATT_R   = 1;
  localparam int         REG_DAC_CTL = 2;
  localparam int         REG_IF_CTL  = 3;
  localparam logic [8:0] REG0_RST    = 9'h0ff;
  localparam logic [8:0] REG1_RST    = 9'h0ff;
  localparam logic [8:0] REG2_RST    = 9'h000;
  localparam logic [8:0] REG3_RST    = 9'h000;

  // field positions
  localparam int R2_MUTE   = 0;
  localparam int R2_DEEMPH = 1;
  localparam int R2_PWDN   = 2;
  localparam int R2_IW_LSB = 3;
  localparam int R2_IW_MSB = 4;
  localparam int R3_I2S    = 0;
  localparam int R3_IZD    = 8;

  // word length codes
  localparam logic [1:0] WL16 = 2'h0;
  localparam logic [1:0] WL20 = 2'h1;
  localparam logic [1:0] WL24 = 2'h2;
  localparam logic [1:0] WL32 = 2'h3;

  // 2-wire receiver states
  typedef enum logic [2:0] {
    TW_IDLE   = 3'b000,
    TW_ADDR   = 3'b001,
    TW_HI     = 3'b010,
    TW_LO     = 3'b011,
    TW_IGNORE = 3'b100
  } dacm_tw_state_e;

endpackage

// ==== include/dacm_pin_if.sv ====
// raw and resynchronised pin levels passed to the synchroniser bank
// assumes the user side drives raw and only reads synced
`timescale 1ns/10ps
interface dacm_pin_if;
  logic [dacm_pkg::SYNC_W-1:0] raw;
  logic [dacm_pkg::SYNC_W-1:0] synced;

  modport sync_mp (input raw, output synced);
  modport user_mp (output raw, input synced);
endinterface

// ==== design/dacm_sync.sv ====
// two flip-flop synchroniser bank for every pin level
// assumes pins are asynchronous to the core clock
`timescale 1ns/10ps
module dacm_sync (
  // clock and reset
  input wire logic       i_clk,
  input wire logic       i_rst,
  // pin levels
  dacm_pin_if.sync_mp    pins
);

  logic [dacm_pkg::SYNC_W-1:0] meta_q;
  logic [dacm_pkg::SYNC_W-1:0] sync_q;

  // first stage feeds only the second; nothing else looks at it
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      meta_q <= '0;
      sync_q <= '0;
    end else begin
      meta_q <= pins.raw;
      sync_q <= meta_q;
    end
  end

  assign pins.synced = sync_q;

endmodule

// ==== bench/dacm_host.sv ====
// host model: frame and bit clocks as a decoder would send them
// assumes the bench picks the frame shape and may stop the frame clock
`timescale 1ns/10ps
module dacm_host (
  // frame shape
  input  wire logic i_half16,
  input  wire logic i_run,
  // audio clocks
  output logic      o_frame_clock,
  output logic      o_bit_clock
);
  // 320 ns bit clock, 32 or 16 a half: 512 or 256 core cycles a frame
  initial begin
    o_bit_clock = 1'b0;
    o_frame_clock = 1'b0;
    forever begin
      repeat (i_half16 ? 16 : 32) begin
        #160 o_bit_clock = 1'b1;
        #160 o_bit_clock = 1'b0;
      end
      // a held frame clock stands for a lost sample rate
      if (i_run) o_frame_clock = ~o_frame_clock;
    end
  end
endmodule

// ==== bench/dacm_top_bench.sv ====
// self-checking bench for the dac control and mute logic
// assumes pins are driven at the falling edge and synced inside
`timescale 1ns/10ps
module dacm_top_bench;
  logic clk = 0, rst = 1, mode = 0, sck = 0, sdi = 0, lat = 0, sel = 0;
  logic mute = 1, und = 0, sv = 0, h16 = 0, run = 1;
  logic [23:0] smp = 24'h000000;
  logic frm, bck, mpin, zn, dm, sd, swm, tw, i2s, dem;
  logic [1:0] wl;
  logic moe, so, soe, ov;
  logic [23:0] ol, orr;
  // open drain data pin: host and device may each pull it low, else it floats high
  wire sda = sdi & (soe | so);
  int n_fail = 0, num_checks = 0;
  dacm_host host (.i_half16(h16), .i_run(run), .o_frame_clock(frm), .o_bit_clock(bck));
  dacm_top uut (.i_core_clk(clk), .i_rst(rst), .i_frame_clock(frm), .i_bit_clock(bck),
    .i_mode_pin(mode), .i_ctrl_clk(sck), .i_serial_data_deemph_pin(sda),
    .i_latch_format_pin(lat), .i_select_wordlen_pin(sel), .i_mute_control_pin(mute),
    .i_mute_undriven(und), .i_sample_valid(sv), .i_sample_left(smp), .i_sample_right(smp),
    .o_mute_control_pin(mpin), .o_mute_control_oe_n(moe), .o_sdi_out(so), .o_sdi_oe_n(soe),
    .o_zero_n(zn), .o_dac_mute(dm), .o_dac_shutdown(sd), .o_sw_mode(swm),
    .o_three_wire(tw), .o_fmt_i2s(i2s), .o_word_len(wl), .o_deemph(dem),
    .o_out_valid(ov), .o_out_left(ol), .o_out_right(orr));
  // 25 MHz core clock
  initial forever #20 clk = ~clk;
  task automatic tick(input int n);
    repeat (n) @(negedge clk);
  endtask
  task automatic chk(input logic [3:0] got, input logic [3:0] exp);
    num_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic chk_smp(input logic [47:0] got, input logic [47:0] exp);
    num_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic samples(input int n, input logic [23:0] v);
    smp = v;
    repeat (n) begin
      sv = 1'b1;
      tick(1);
      chk(ov, 4'h1);
      sv = 1'b0;
      tick(1);
    end
    tick(4);
  endtask
  task automatic formats();
    logic [1:0] e;
    for (int i = 0; i < 4; i++) begin
      {lat, sel} = i[1:0];
      sdi = i[0];
      e = (i == 1) ? dacm_pkg::WL20 : (i == 2) ? dacm_pkg::WL16 : dacm_pkg::WL24;
      tick(6);
      chk({i2s, wl, dem}, {i[1], e, i[0]});
    end
  endtask
  task automatic half16();
    {lat, sel} = 2'h1;
    h16 = 1'b1;
    tick(1200);
    chk(wl, dacm_pkg::WL16);
    h16 = 1'b0;
    tick(1200);
    chk(wl, dacm_pkg::WL20);
  endtask
  task automatic automute();
    und = 1'b1;
    // the undriven sense needs two clocks through the synchroniser before counting starts
    tick(4);
    samples(1023, 24'h000000);
    chk({zn, mpin}, 4'h3);
    samples(1, 24'h000000);
    chk({zn, mpin, moe, dm}, 4'h1);
    samples(1, 24'h000100);
    chk({zn, mpin, moe, dm}, 4'hc);
  endtask
  task automatic mute_pin();
    samples(1024, 24'h000000);
    und = 1'b0;
    tick(6);
    chk({moe, dm}, 4'h2);
    samples(1, 24'h001000);
    chk_smp({ol, orr}, {2{24'h001000}});
    mute = 1'b0;
    tick(6);
    chk(dm, 4'h1);
    samples(1, 24'h001000);
    chk_smp({ol, orr}, {2{24'h000fc0}});
    mute = 1'b1;
    tick(6);
    samples(1, 24'h000001);
    chk_smp({ol, orr}, {2{24'h000001}});
  endtask
  // one byte msb first, then the acknowledge clock; slow clock leaves room for the ack
  task automatic tw_byte(input logic [7:0] b, input logic [3:0] ack);
    for (int i = 7; i >= 0; i--) begin
      sdi = b[i];
      tick(8);
      sck = 1'b1;
      tick(8);
      sck = 1'b0;
    end
    sdi = 1'b1;
    tick(8);
    sck = 1'b1;
    tick(4);
    chk({soe, sda}, ack);
    tick(4);
    sck = 1'b0;
  endtask
  task automatic tw_write(input logic [7:0] a, input logic [15:0] w, input logic [3:0] ack);
    sdi = 1'b1;
    sck = 1'b1;
    tick(8);
    sdi = 1'b0;
    tick(8);
    sck = 1'b0;
    tw_byte(a, ack);
    if (ack == 4'h0) begin
      tw_byte(w[15:8], 4'h0);
      tw_byte(w[7:0], 4'h0);
    end
    sdi = 1'b0;
    tick(8);
    sck = 1'b1;
    tick(8);
    sdi = 1'b1;
    tick(8);
  endtask
  task automatic two_wire();
    mode = 1'b1;
    {lat, sel} = 2'h1;
    tick(6);
    tw_write(8'h34, 16'h0000, 4'h3);
    tw_write(8'h36, 16'h0701, 4'h0);
    tick(6);
    chk({tw, i2s}, 4'h1);
    samples(1024, 24'h000000);
    chk({zn, dm}, 4'h1);
    samples(1, 24'h000001);
    chk({zn, dm}, 4'h2);
  endtask
  task automatic ratio_loss();
    run = 1'b0;
    tick(4300);
    chk(sd, 4'h1);
    run = 1'b1;
    tick(1600);
    chk(sd, 4'h0);
  endtask
  task automatic three_wire(input logic [15:0] w);
    mode = 1'b1;
    {lat, sel, sck} = 3'h0;
    tick(6);
    chk({swm, tw}, 4'h2);
    lat = 1'b1;
    tick(4);
    lat = 1'b0;
    tick(4);
    chk(tw, 4'h1);
    for (int i = 15; i >= 0; i--) begin
      sdi = w[i];
      tick(3);
      sck = 1'b1;
      tick(3);
      sck = 1'b0;
    end
    lat = 1'b1;
    tick(4);
    lat = 1'b0;
    tick(4);
    chk(wl, dacm_pkg::WL20);
  endtask
  task automatic close_out();
    $display("checks %0d mismatches %0d", num_checks, n_fail);
    if (n_fail == 0 && num_checks > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  initial begin
    tick(5);
    rst = 1'b0;
    chk({sd, dm, zn}, 4'h7);
    tick(1600);
    chk(sd, 4'h0);
    formats();
    half16();
    automute();
    mute_pin();
    ratio_loss();
    two_wire();
    three_wire(16'h0408);
    close_out();
  end
endmodule
